// [flash_lock_pkg.sv]
// Package: memory map, lock encodings and reset values for flash protection
package flash_lock_pkg;
    // Lock byte encodings
    localparam logic [7:0] LOCK_OPEN       = 8'hff;
    localparam logic [7:0] LOCK_CFG_ON     = 8'h00;
    localparam logic [7:0] LOCK_ALL_PAGES  = 8'h80;
    localparam logic [7:0] LOCK_RST_VALUE  = 8'hff;
    // Code area geometry
    localparam int         PAGE_COUNT      = 32;
    localparam int         PAGE_BYTES      = 512;
    localparam int         PAGE_SHIFT      = 9;
    localparam int         TOP_PAGE        = 31;
    // Code space map (byte addresses, 16 bit)
    localparam logic [15:0] CODE_BASE      = 16'h0000;
    localparam logic [15:0] CODE_LAST      = 16'h3fff;
    localparam logic [15:0] CODE_LOCK_LOW  = 16'h3ffe;
    localparam logic [15:0] CODE_LOCK_HIGH = 16'h3fff;
    localparam logic [15:0] UCFG_BASE      = 16'h4000;
    localparam logic [15:0] UCFG_LAST      = 16'h41ff;
    localparam logic [15:0] UCFG_LOCK      = 16'h41ff;
    localparam logic [15:0] FCFG1_BASE     = 16'h4200;
    localparam logic [15:0] FCFG1_LAST     = 16'h447f;
    localparam logic [15:0] FCFG2_BASE     = 16'h4480;
    localparam logic [15:0] FCFG2_LAST     = 16'h467f;
    localparam logic [15:0] ROM_BASE       = 16'h8000;
    localparam logic [15:0] ROM_LAST       = 16'hffff;
    // Flash line size for the line program command
    localparam int         LINE_BYTES      = 64;
    // External data space: retention memory window
    localparam logic [15:0] RET_BASE       = 16'h0000;
    localparam logic [15:0] RET_LAST       = 16'h007f;
    // Internal data space split
    localparam logic [7:0] IDATA_UPPER     = 8'h80;
    // Flash commands
    localparam logic [1:0] CMD_NONE        = 2'h0;
    localparam logic [1:0] CMD_SECTOR_ERASE = 2'h1;
    localparam logic [1:0] CMD_WRITE_LINE  = 2'h2;
    localparam logic [1:0] CMD_CHIP_ERASE  = 2'h3;
    // Value returned on a refused read
    localparam logic [7:0] BLANK_DATA      = 8'h00;
endpackage

// [flash_lock_protection.sv]
// Flash lock decoding, access permission and memory-map select logic
// How it works
// R1 - Last byte of each sector is its lock
// R2 - Value 0xff leaves the area unlocked
// R3 - New lock values apply after next reset
// R4 - Code flash split into 32 pages of 512
// R5 - Low lock grows up, high grows down
// R6 - Any code lock set also locks page 31
// R7 - Low lock 0xfe page0, each step adds one
// R8 - High lock 0xfe page31, each step adds one
// R9 - Programmer never writes code locks below 0x80
// R10 - Config lock 0x00 blocks write and erase
// R11 - Code locked: no write/erase, chip erase once
// R12 - Unlocked: chip erase only in normal mode
// R13 - Programmer sets code locks as final step
// R14 - Program mode offers sector erase, line write
// R15 - Config lock settable in either mode
// R16 - Factory sectors immutable and read protected
// R17 - Factory lock one blocks factory write/erase
// R18 - Code space map of flash and library
// R19 - Retention memory in external data space
// R20 - Upper direct addresses reach special registers
// R21 - Firmware slows clock before config writes
// R22 - Refused requests change nothing, read blank
`timescale 1ns/1ps
module flash_lock_protection
    import flash_lock_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // Access mode: high in program mode, low in normal mode
    input  wire logic        prog_mode_in,
    // Lock bytes as read from flash, sampled at reset release
    input  wire logic [7:0]  low_end_code_lock_in,
    input  wire logic [7:0]  high_end_code_lock_in,
    input  wire logic [7:0]  config_sector_lock_in,
    input  wire logic [7:0]  factory_lock_one_in,
    input  wire logic [7:0]  factory_lock_four_in,
    // Flash request from programmer or firmware
    input  wire logic        req_valid_in,
    input  wire logic        req_read_in,
    input  wire logic [1:0]  req_cmd_in,
    input  wire logic [15:0] req_addr_in,
    input  wire logic [7:0]  flash_rdata_in,
    // Data-space decode request
    input  wire logic        data_valid_in,
    input  wire logic        data_indirect_in,
    input  wire logic [7:0]  data_addr_in,
    // Flash request result
    output logic             grant_out,
    output logic             refuse_out,
    output logic             flash_read_out,
    output logic             flash_sector_erase_out,
    output logic             flash_line_write_out,
    output logic             flash_chip_erase_out,
    output logic [15:0]      flash_addr_out,
    output logic [7:0]       rdata_out,
    // Memory map selects for the code-space request
    output logic             sel_rom_out,
    // Data-space selects
    output logic             sel_sfr_out,
    output logic             sel_idata_out,
    // Live lock state
    output logic [31:0]      page_locked_out,
    output logic             code_locked_out,
    output logic             config_locked_out
);

    // Masks are pure decodes of a held lock byte,
    // so live flash contents never reach them
    // Values below 0x80 are never written
    // Page lock mask from the low lock: pages 0..(0xfe - v) locked
    function automatic logic [31:0] low_mask(input logic [7:0] v);
        logic [31:0] m;
        logic [7:0]  last;
        m    = '0;
        last = 8'hfe - v;
        for (int i = 0; i < PAGE_COUNT; i++) begin
            if (v != LOCK_OPEN && 8'(i) <= last) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Mirror of the low decode, counted from the top
    // The span is 0x7e at 0x80, more than 31, so 0x80 covers every page
    // Page lock mask from the high lock: pages (31 - (0xfe - v))..31 locked
    function automatic logic [31:0] high_mask(input logic [7:0] v);
        logic [31:0] m;
        logic [7:0]  span;
        m    = '0;
        span = 8'hfe - v;
        for (int i = 0; i < PAGE_COUNT; i++) begin
            if (v != LOCK_OPEN && 8'(TOP_PAGE - i) <= span) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Bounds are inclusive so a sector's lock byte is
    // inside its own sector
    // Address range check, used for every region
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Lock bytes held from reset; flash writes to the lock lines change
    // only the flash array, so protection moves only at the next reset
    logic [7:0]  low_lock_ff;
    logic [7:0]  high_lock_ff;
    logic [7:0]  cfg_lock_ff;
    logic [7:0]  fl_one_ff;
    logic [7:0]  fl_four_ff;
    logic        capture_ff;     // High in first cycle after reset release
    // Lock views are flops, one cycle behind the
    // holding registers; only matters after reset
    logic [31:0] page_ff;        // Locked page map
    logic        code_ff;        // Any code lock set
    logic        cfg_ff;         // Config sector locked

    // Registered outputs
    logic        grant_ff;
    logic        refuse_ff;
    logic        rd_ff;
    logic        se_ff;
    logic        wl_ff;
    logic        ce_ff;
    logic [15:0] addr_ff;
    logic [7:0]  rdata_ff;
    logic        rom_ff;
    logic        sfr_ff;
    logic        idata_ff;

    // Lock decode
    wire logic        code_lock_on   = (low_lock_ff != LOCK_OPEN) ||
                                       (high_lock_ff != LOCK_OPEN);   // R2
    wire logic [31:0] page_mask      = low_mask(low_lock_ff) |       // R5 R7
                                       high_mask(high_lock_ff) |     // R8
                                       {code_lock_on, 31'h0};         // R6
    wire logic        cfg_lock_on    = (cfg_lock_ff == LOCK_CFG_ON);  // R10 R1

    // Regions never overlap: at most one hit is high
    // The gap below the library hits nothing, so every
    // access to it is refused
    // Region decode of the request address
    wire logic        hit_code  = in_range(req_addr_in, CODE_BASE, CODE_LAST);   // R18
    wire logic        hit_ucfg  = in_range(req_addr_in, UCFG_BASE, UCFG_LAST);
    wire logic        hit_fcfg1 = in_range(req_addr_in, FCFG1_BASE, FCFG1_LAST);
    wire logic        hit_fcfg2 = in_range(req_addr_in, FCFG2_BASE, FCFG2_LAST);
    wire logic        hit_rom   = in_range(req_addr_in, ROM_BASE, ROM_LAST);
    wire logic [4:0]  page_idx  = req_addr_in[PAGE_SHIFT +: 5];                 // R4
    // Only code addresses use the page index
    wire logic        page_hit  = page_mask[page_idx];

    // Read permission: locked code pages unreadable in normal mode only;
    // factory sectors readable only while their lock is open
    wire logic        rd_ok = hit_rom ||
                              (hit_code && !(page_hit && !prog_mode_in)) ||     // R11
                              hit_ucfg ||                                       // R10
                              (hit_fcfg1 && fl_one_ff == LOCK_OPEN) ||          // R16
                              (hit_fcfg2 && fl_four_ff == LOCK_OPEN);           // R16

    // Program mode takes only sector erase and line
    // write; normal mode leaves it to the targets
    // Chip erase is judged on its own, never on the
    // sector locks
    // Modify permission per command
    wire logic        cmd_legal = prog_mode_in ? (req_cmd_in == CMD_SECTOR_ERASE ||
                                                  req_cmd_in == CMD_WRITE_LINE)
                                               : (req_cmd_in != CMD_NONE);      // R14
    wire logic        wr_target = (hit_code && !code_lock_on) ||               // R11
                                  (hit_ucfg && !cfg_lock_on);                  // R10 R15
    wire logic        ce_ok     = hit_code && !prog_mode_in;                   // R11 R12
    wire logic        mod_ok    = cmd_legal && !hit_fcfg1 && !hit_fcfg2 &&     // R16 R17
                                  !hit_rom &&
                                  ((req_cmd_in == CMD_CHIP_ERASE) ? ce_ok : wr_target);

    // The command is ignored on reads
    wire logic        ok_now    = req_read_in ? rd_ok : mod_ok;
    wire logic        go        = req_valid_in && ok_now;                      // R22
    // Exactly one of go and stop per request
    wire logic        stop      = req_valid_in && !ok_now;
    // Line write addresses align to the line start
    wire logic [15:0] line_addr = req_addr_in & ~16'(LINE_BYTES - 1);          // R14

    // Upper half is shared: direct reaches special
    // registers, indirect reaches data memory
    // Data-space decode
    wire logic        upper     = data_addr_in >= IDATA_UPPER;
    wire logic        to_sfr    = data_valid_in && upper && !data_indirect_in; // R20
    wire logic        to_idata  = data_valid_in && !(upper && !data_indirect_in);

    // Capture lock bytes once, the cycle after reset release
    // One capture point keeps all locks from one reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            capture_ff <= 1'b1;
        end else begin
            // Drops after one cycle, stays low till reset
            capture_ff <= 1'b0;
        end
    end

    // Lock holding registers; only reset refreshes them
    // Reset opens the code locks but closes the factory
    // ones, so factory bytes stay hidden before capture; code reads in the capture cycle return flash data
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            low_lock_ff  <= LOCK_RST_VALUE;
            high_lock_ff <= LOCK_RST_VALUE;
            cfg_lock_ff  <= LOCK_RST_VALUE;
            fl_one_ff    <= 8'h00;   // Factory areas closed until sampled
            fl_four_ff   <= 8'h00;
        end else if (capture_ff) begin                                         // R3
            low_lock_ff  <= low_end_code_lock_in;
            high_lock_ff <= high_end_code_lock_in;
            cfg_lock_ff  <= config_sector_lock_in;
            fl_one_ff    <= factory_lock_one_in;
            fl_four_ff   <= factory_lock_four_in;
        end
    end

    // Request strobes; requests are held off during the capture cycle
    // A request there would be judged on open code locks,
    // so it gets neither grant nor refusal
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || capture_ff) begin
            grant_ff  <= 1'b0;
            refuse_ff <= 1'b0;
            rd_ff     <= 1'b0;
            se_ff     <= 1'b0;
            wl_ff     <= 1'b0;
            ce_ff     <= 1'b0;
        end else begin
            grant_ff  <= go;
            refuse_ff <= stop;                                                 // R22
            rd_ff     <= go && req_read_in;
            se_ff     <= go && !req_read_in && req_cmd_in == CMD_SECTOR_ERASE;
            wl_ff     <= go && !req_read_in && req_cmd_in == CMD_WRITE_LINE;
            ce_ff     <= go && !req_read_in && req_cmd_in == CMD_CHIP_ERASE;
        end
    end

    // Address, data and selects
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            addr_ff  <= 16'h0000;
            rdata_ff <= BLANK_DATA;
            rom_ff   <= 1'b0;
            sfr_ff   <= 1'b0;
            idata_ff <= 1'b0;
        end else begin
            // Only line writes align; reads keep their byte
            addr_ff  <= (!req_read_in && req_cmd_in == CMD_WRITE_LINE) ? line_addr
                                                                        : req_addr_in;
            // Blank data on refusal; a read in the capture cycle returns flash data even from locked pages
            rdata_ff <= (go && req_read_in) ? flash_rdata_in : BLANK_DATA;     // R22
            rom_ff   <= go && hit_rom;
            sfr_ff   <= to_sfr;
            idata_ff <= to_idata;
        end
    end

    // Lock views, refreshed each cycle from the held locks
    // Reset shows an open map, like the lock reset value
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            page_ff <= 32'h00000000;
            code_ff <= 1'b0;
            cfg_ff  <= 1'b0;
        end else begin
            page_ff <= page_mask;                                              // R6
            code_ff <= code_lock_on;                                           // R2
            cfg_ff  <= cfg_lock_on;                                            // R10
        end
    end

    // Every output comes straight from a flop
    assign grant_out              = grant_ff;
    assign refuse_out             = refuse_ff;
    assign flash_read_out         = rd_ff;
    assign flash_sector_erase_out = se_ff;
    assign flash_line_write_out   = wl_ff;
    assign flash_chip_erase_out   = ce_ff;
    assign flash_addr_out         = addr_ff;
    assign rdata_out              = rdata_ff;
    assign sel_rom_out            = rom_ff;
    assign sel_sfr_out            = sfr_ff;
    assign sel_idata_out          = idata_ff;
    // Lock views come from their own flops
    assign page_locked_out        = page_ff;
    assign code_locked_out        = code_ff;
    assign config_locked_out      = cfg_ff;

endmodule

// [flash_lock_checker.sv]
// Checker: request answers, lock decode and data-space selects
`timescale 1ns/1ps
module flash_lock_checker
    import flash_lock_pkg::*;
(
    // Clock, reset and requests
    input logic        sys_clk_in, rst_in, prog_mode_in, req_valid_in, req_read_in,
    input logic [1:0]  req_cmd_in,
    input logic [15:0] req_addr_in,
    input logic [7:0]  flash_rdata_in, data_addr_in, rdata_out,
    input logic        data_valid_in, data_indirect_in, sel_sfr_out, sel_idata_out,
    // Answers and lock state
    input logic        grant_out, refuse_out, flash_read_out, flash_sector_erase_out,
    input logic        flash_line_write_out, flash_chip_erase_out,
    input logic [31:0] page_locked_out,
    input logic        code_locked_out, config_locked_out
);
    logic [1:0] live_ff;                    // Edges since release, 0 is the capture cycle
    wire taken    = req_valid_in && live_ff != 2'h0;
    wire modify   = taken && !req_read_in && req_cmd_in != CMD_NONE;
    wire in_code  = req_addr_in <= CODE_LAST;
    wire in_ucfg  = req_addr_in >= UCFG_BASE && req_addr_in <= UCFG_LAST;
    wire page_hit = page_locked_out[req_addr_in[13:9]];
    wire up_dir   = !data_indirect_in && data_addr_in >= IDATA_UPPER;
    wire strobes  = flash_read_out || flash_sector_erase_out || flash_line_write_out
                    || flash_chip_erase_out;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Saturating count keeps the capture cycle apart from live traffic
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) live_ff <= 2'h0;
        else if (live_ff != 2'h3) live_ff <= live_ff + 2'h1;
    end
    property p_single; taken |=> grant_out != refuse_out; endproperty
    a_single: assert property (p_single) else $error("Request not answered once");
    property p_quiet; (!req_valid_in || live_ff == 2'h0) |=> !grant_out && !refuse_out && !strobes;
    endproperty
    a_quiet: assert property (p_quiet) else $error("Answer without request");
    property p_blank; refuse_out |-> rdata_out == BLANK_DATA && !strobes; endproperty
    a_blank: assert property (p_blank) else $error("Refused access had effect");
    property p_read; taken && req_read_in |=> flash_read_out == grant_out
        && rdata_out == (grant_out ? $past(flash_rdata_in) : BLANK_DATA); endproperty
    a_read: assert property (p_read) else $error("Read data wrong");
    property p_page_read; taken && req_read_in && in_code && !prog_mode_in
        |=> grant_out == !$past(page_hit); endproperty
    a_page_read: assert property (p_page_read) else $error("Page read lock ignored");
    property p_top; code_locked_out == page_locked_out[31]
        && (code_locked_out || page_locked_out == 32'h0); endproperty
    a_top: assert property (p_top) else $error("Top page lock wrong");
    property p_hold; live_ff == 2'h3 |-> $stable(page_locked_out) && $stable(config_locked_out);
    endproperty
    a_hold: assert property (p_hold) else $error("Lock state moved without reset");
    property p_code_mod; modify && in_code && code_locked_out && req_cmd_in != CMD_CHIP_ERASE
        |=> refuse_out; endproperty
    a_code_mod: assert property (p_code_mod) else $error("Locked code modified");
    property p_prog_chip; modify && prog_mode_in && req_cmd_in == CMD_CHIP_ERASE |=> refuse_out;
    endproperty
    a_prog_chip: assert property (p_prog_chip) else $error("Chip erase in program mode");
    property p_cfg; modify && in_ucfg && config_locked_out |=> refuse_out; endproperty
    a_cfg: assert property (p_cfg) else $error("Locked config sector modified");
    property p_sel; data_valid_in |=> sel_sfr_out == $past(up_dir) && sel_idata_out == !sel_sfr_out;
    endproperty
    a_sel: assert property (p_sel) else $error("Data-space select wrong");
    // Main scenarios reached
    c_write: cover property (grant_out && flash_line_write_out);
    c_chip: cover property (grant_out && flash_chip_erase_out);
    c_cfg: cover property (refuse_out && config_locked_out);
endmodule
bind flash_lock_protection flash_lock_checker chk (.*);

// [flash_array_model.sv]
// Flash array model: lock bytes at sector ends and a data pattern
`timescale 1ns/1ps
module flash_array_model
    import flash_lock_pkg::*;
#(
    parameter logic [7:0] FACTORY_ONE  = 8'h00,  // Fixed at manufacture
    parameter logic [7:0] FACTORY_FOUR = 8'hff
)(
    // Clock and lock-byte program port
    input  wire logic        sys_clk_in,
    input  wire logic        wr_en_in,
    input  wire logic [15:0] wr_addr_in,
    input  wire logic [7:0]  wr_data_in,
    // Read port and lock bytes
    input  wire logic [15:0] rd_addr_in,
    output logic [7:0]       rd_data_out,
    output logic [7:0]       low_lock_out, high_lock_out, cfg_lock_out, one_lock_out, four_lock_out
);
    logic [7:0] low_ff = LOCK_OPEN;   // Erased flash reads as open
    logic [7:0] high_ff = LOCK_OPEN;
    logic [7:0] cfg_ff = LOCK_OPEN;
    // Undefined values are dropped; factory bytes never change
    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in && wr_addr_in == CODE_LOCK_LOW && wr_data_in[7]) low_ff <= wr_data_in;
        if (wr_en_in && wr_addr_in == CODE_LOCK_HIGH && wr_data_in[7]) high_ff <= wr_data_in;
        if (wr_en_in && wr_addr_in == UCFG_LOCK && wr_data_in inside {LOCK_OPEN, LOCK_CFG_ON})
            cfg_ff <= wr_data_in;
    end
    assign {low_lock_out, high_lock_out, cfg_lock_out} = {low_ff, high_ff, cfg_ff};
    assign {one_lock_out, four_lock_out} = {FACTORY_ONE, FACTORY_FOUR};
    // Lock places read back their byte, all else a fixed pattern
    assign rd_data_out = rd_addr_in == CODE_LOCK_LOW ? low_ff : rd_addr_in == CODE_LOCK_HIGH ?
                         high_ff : rd_addr_in == UCFG_LOCK ? cfg_ff :
                         rd_addr_in[7:0] ^ rd_addr_in[15:8] ^ 8'h3c;
endmodule

// [tb.sv]
// Testbench: lock tables, random requests and data-space decode
`timescale 1ns/1ps
module tb;
    import flash_lock_pkg::*;
    localparam logic [7:0] F1 = 8'h00, F4 = 8'hff;  // Factory bytes held by the model
    logic sys_clk_in = 1'b0, rst_in = 1'b1, prog_mode_in = 1'b0, req_valid_in = 1'b0;
    logic req_read_in = 1'b0, data_valid_in = 1'b0, data_indirect_in = 1'b0, wr_en = 1'b0;
    logic [1:0]  req_cmd_in = CMD_NONE;
    logic [15:0] req_addr_in = 16'h0000, wr_addr = 16'h0000, flash_addr_out;
    logic [7:0]  data_addr_in = 8'h00, wr_data = 8'h00, lo_q, hi_q, cf_q, rdata_out;
    wire  [7:0]  flash_rdata_in, low_end_code_lock_in, high_end_code_lock_in;
    wire  [7:0]  config_sector_lock_in, factory_lock_one_in, factory_lock_four_in;
    logic grant_out, refuse_out, flash_read_out, flash_sector_erase_out, flash_line_write_out;
    logic flash_chip_erase_out, sel_rom_out, sel_sfr_out, sel_idata_out;
    logic code_locked_out, config_locked_out;
    logic [31:0] page_locked_out, seed;
    int fail_count = 0, check_count = 0;
    logic [7:0]  lo_tab [6] = '{8'hfe, 8'hff, 8'h80, 8'hff, 8'hfc, 8'hff};
    logic [7:0]  hi_tab [6] = '{8'hff, 8'hfe, 8'hff, 8'h80, 8'hfd, 8'hff};
    logic [15:0] corner [4] = '{16'h0000, 16'h3e00, CODE_LOCK_HIGH, UCFG_LOCK};
    flash_array_model #(.FACTORY_ONE(F1), .FACTORY_FOUR(F4)) flash_model (
        .sys_clk_in(sys_clk_in), .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
        .rd_addr_in(req_addr_in), .rd_data_out(flash_rdata_in),
        .low_lock_out(low_end_code_lock_in), .high_lock_out(high_end_code_lock_in),
        .cfg_lock_out(config_sector_lock_in), .one_lock_out(factory_lock_one_in),
        .four_lock_out(factory_lock_four_in));
    flash_lock_protection DUT (.*);
    initial begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Page lock from the held low and high code lock bytes
    function automatic logic lock_of(input int pg);
        if (lo_q != LOCK_OPEN && (pg <= int'(8'hfe - lo_q) || pg == TOP_PAGE)) return 1'b1;
        return hi_q != LOCK_OPEN && pg + int'(8'hfe - hi_q) >= TOP_PAGE;
    endfunction
    function automatic logic [31:0] pages();
        for (int p = 0; p < PAGE_COUNT; p++) pages[p] = lock_of(p);
    endfunction
    function automatic logic allowed(input logic rd, input logic [1:0] cmd, input logic [15:0] a);
        if (a <= CODE_LAST) begin
            if (rd) return prog_mode_in || !lock_of(int'(a[13:9]));
            if (cmd == CMD_CHIP_ERASE) return !prog_mode_in;
            return lo_q == LOCK_OPEN && hi_q == LOCK_OPEN;
        end
        if (rd) return a >= ROM_BASE || a <= UCFG_LAST || (a <= FCFG1_LAST ? F1 : F4) == LOCK_OPEN;
        return a <= UCFG_LAST && cmd != CMD_CHIP_ERASE && cf_q != LOCK_CFG_ON;
    endfunction
    // Sync reset; a request in the capture cycle must go unanswered
    task automatic do_reset();
        rst_in = 1'b1;
        repeat (20) @(posedge sys_clk_in);
        #1 {rst_in, req_valid_in, req_read_in} = 3'b011;
        @(posedge sys_clk_in);
        #1 check("capture idle", 32'({grant_out, refuse_out}), 32'h0);
        req_valid_in = 1'b0;
        @(posedge sys_clk_in);
        #1;
    endtask
    // Strobe held across the three writes so it is never re-raised in one step
    task automatic program_locks(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] cf);
        wr_en = 1'b1;
        {wr_addr, wr_data} = {CODE_LOCK_LOW, lo};
        @(posedge sys_clk_in);
        #1 {wr_addr, wr_data} = {CODE_LOCK_HIGH, hi};
        @(posedge sys_clk_in);
        #1 {wr_addr, wr_data} = {UCFG_LOCK, cf};
        @(posedge sys_clk_in);
        #1 wr_en = 1'b0;
    endtask
    // Back-to-back requests; each answer is checked one cycle later
    task automatic run_requests(input int n);
        logic [31:0] r;
        logic [15:0] a, ea;
        logic [16:0] ev;
        logic        g, sfr;
        for (int i = 0; i <= n; i++) begin
            if (i > 0) begin
                check("answer", 32'({rdata_out, grant_out, refuse_out, flash_read_out,
                    flash_sector_erase_out, flash_line_write_out, flash_chip_erase_out,
                    sel_rom_out, sel_sfr_out, sel_idata_out}), 32'(ev));
                if (g) check("flash address", 32'(flash_addr_out), 32'(ea));
            end
            r = $random(seed);
            case (r[18:16])
                3'h4: a = UCFG_BASE | 16'(r[8:0]);
                3'h5: a = FCFG1_BASE + 16'(r[9:0] % 640);
                3'h6: a = FCFG2_BASE + 16'(r[8:0]);
                3'h7: a = ROM_BASE | 16'(r[14:0]);
                default: a = 16'(r[13:0]);
            endcase
            if (i < 4) a = corner[i];
            {req_valid_in, req_read_in, prog_mode_in, req_addr_in} = {i < n, r[20], r[21], a};
            req_cmd_in = r[1:0] == 2'h0 ? CMD_WRITE_LINE : r[1:0];
            {data_valid_in, data_indirect_in, data_addr_in} = {i < n ? r[23:22] : 2'h0, r[31:24]};
            #1 g = req_valid_in && allowed(req_read_in, req_cmd_in, a);
            sfr = data_valid_in && !data_indirect_in && data_addr_in >= IDATA_UPPER;
            ev = {g && req_read_in ? flash_rdata_in : BLANK_DATA, g, req_valid_in && !g,
                  g && req_read_in, g && !req_read_in && req_cmd_in == CMD_SECTOR_ERASE,
                  g && !req_read_in && req_cmd_in == CMD_WRITE_LINE,
                  g && !req_read_in && req_cmd_in == CMD_CHIP_ERASE, g && a >= ROM_BASE,
                  sfr, data_valid_in && !sfr};
            ea = !req_read_in && req_cmd_in == CMD_WRITE_LINE ? a & 16'hffc0 : a;
            @(posedge sys_clk_in);
            #1;
        end
    endtask
    initial begin
        seed = 32'hd0bc0d9b;
        {lo_q, hi_q, cf_q} = {3{LOCK_OPEN}};
        do_reset();
        for (int t = 0; t < 7; t++) begin
            check("page map", page_locked_out, pages());
            check("lock flags", 32'({code_locked_out, config_locked_out}),
                32'({lo_q != LOCK_OPEN || hi_q != LOCK_OPEN, cf_q == LOCK_CFG_ON}));
            run_requests(60);
            $display("Lock set %0d done, %0d checks so far", t, check_count);
            if (t < 6) begin
                program_locks(lo_tab[t], hi_tab[t], t[0] ? LOCK_CFG_ON : LOCK_OPEN);
                check("held map", page_locked_out, pages());
                {lo_q, hi_q, cf_q} = {lo_tab[t], hi_tab[t], t[0] ? LOCK_CFG_ON : LOCK_OPEN};
                do_reset();
            end
        end
        stop_test();
    end
    // Hang guard
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
endmodule
